// [pkg/spv_regs.svh]
// timing counts and address map for the serial program/verify port
`ifndef SPV_REGS_SVH
`define SPV_REGS_SVH
`define SPV_SYS_PERIOD_NS 5
`define SPV_GAP_US 1
`define SPV_GAP_CYC ((`SPV_GAP_US * 1000 + `SPV_SYS_PERIOD_NS - 1) / `SPV_SYS_PERIOD_NS)
`define SPV_HOLD_MS 2
`define SPV_HOLD_CYC ((`SPV_HOLD_MS * 1000000 + `SPV_SYS_PERIOD_NS - 1) / `SPV_SYS_PERIOD_NS)
`define SPV_PULSE_US 100
`define SPV_PULSE_CYC ((`SPV_PULSE_US * 1000 + `SPV_SYS_PERIOD_NS - 1) / `SPV_SYS_PERIOD_NS)
`define SPV_CMD_BITS 6
`define SPV_FRAME_BITS 16
`define SPV_CFG_BASE 14'h2000
`define SPV_CFG_SEG_MASK 14'h00FF
`define SPV_PROG_TOP 14'h0FB3
`define SPV_CAL_BASE 14'h0FC0
`define SPV_ID_LAST 14'h2003
`define SPV_CMD_LOAD_CFG 6'h00
`define SPV_CMD_LOAD_DATA 6'h01
`define SPV_CMD_READ_DATA 6'h04
`define SPV_CMD_INC_ADDR 6'h03
`define SPV_CMD_BEGIN_PROG 6'h08
`define SPV_CMD_END_PROG 6'h0E
`define SPV_HALF_DIV 5
`endif

// [pkg/spv_pkg.sv]
// types shared by both ends of the serial program/verify port
`default_nettype none
package spv_pkg;
  typedef logic [13:0] word_t;
  typedef logic [5:0] cmd_t;
  typedef enum logic [1:0] {
    ph_cmd = 2'b00,
    ph_load = 2'b01,
    ph_read = 2'b10
  } phase_t;
endpackage
`default_nettype wire

// [pkg/spv_if.sv]
// link between programmer and device: clock, data, entry pin
`default_nettype none
interface spv_if;
  logic prog_clock_pin;
  logic high_voltage_entry_pin;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic prog_data_pin;
  // wired level: driver wins, idle pulls low
  assign prog_data_pin = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 1'b0);
  modport device (
    input prog_clock_pin, high_voltage_entry_pin, prog_data_pin,
    output dev_data_o, dev_data_oe
  );
  modport host (
    input prog_data_pin,
    output prog_clock_pin, high_voltage_entry_pin, host_data_o, host_data_oe
  );
endinterface
`default_nettype wire

// [rtl/spv_device.sv]
// device end: command decode, frames, word pointer and memory
`default_nettype none
`include "spv_regs.svh"
module spv_device #(
  parameter int MEM_WORDS = 4096,
  parameter int CFG_WORDS = 256
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  spv_if.device link,
  output logic o_core_reset,
  output logic o_prog_active,
  output spv_pkg::word_t o_word_pointer,
  output spv_pkg::cmd_t o_last_cmd
);
  import spv_pkg::*;

  initial begin
    if (MEM_WORDS != 4096 || CFG_WORDS != 256) $error("unsupported memory size");
  end

  // ==========================================================
  // pin synchronisers
  logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2, hv_s1, hv_s2, hv_s3;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      {clk_s1, clk_s2, clk_s3, dat_s1, dat_s2, hv_s1, hv_s2, hv_s3} <= 8'h00;
    end else begin
      clk_s1 <= link.prog_clock_pin;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dat_s1 <= link.prog_data_pin;
      dat_s2 <= dat_s1;
      hv_s1 <= link.high_voltage_entry_pin;
      hv_s2 <= hv_s1;
      hv_s3 <= hv_s2;
    end
  end
  wire logic rise = clk_s2 & ~clk_s3;
  wire logic fall = ~clk_s2 & clk_s3;
  // entry only counts with clock and data low at the rising entry pin
  wire logic enter = hv_s2 & ~hv_s3 & ~clk_s2 & ~dat_s2;
  wire logic leave = ~hv_s2;

  // ==========================================================
  // mode flag and core reset
  logic mode_reg;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode_reg <= 1'b0;
    end else if (leave) begin
      mode_reg <= 1'b0;
    end else if (enter) begin
      mode_reg <= 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_core_reset <= 1'b1;
    end else begin
      o_core_reset <= hv_s2;
    end
  end

  // ==========================================================
  // serial shifter, shared by command and frame phases
  phase_t phase_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] sh_reg;
  cmd_t cmd_next;
  word_t rd_word;
  word_t ptr_reg;
  logic [13:0] mem [0:MEM_WORDS-1];
  logic [13:0] cfg [0:CFG_WORDS-1];
  word_t load_reg;
  logic loaded_reg;
  logic [13:0] mem_q, cfg_q;
  assign cmd_next = cmd_t'({dat_s2, sh_reg[15:11]});
  assign mem_q = mem[ptr_reg[11:0]];
  assign cfg_q = cfg[ptr_reg[7:0]];
  // id words and all config locations read raw, no protection mask
  assign rd_word = ptr_reg[13] ? cfg_q : mem_q;

  // word pointer increment with per-space wrap
  function automatic word_t ptr_inc(input word_t p);
    word_t n;
    n = p + 14'h0001;
    if (p[13]) begin
      n = {1'b1, n[12:0]};
    end else begin
      n = {1'b0, n[12:0]};
    end
    return n;
  endfunction

  wire logic frame_done = (bit_cnt_reg == 5'(`SPV_FRAME_BITS - 1)) && fall;
  wire logic cmd_done = (bit_cnt_reg == 5'(`SPV_CMD_BITS - 1)) && fall;

  // bit counting and phase sequencing
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !mode_reg) begin
      phase_reg <= ph_cmd;
      bit_cnt_reg <= 5'h00;
      sh_reg <= 16'h0000;
      o_last_cmd <= 6'h00;
    end else if (fall) begin
      sh_reg <= {dat_s2, sh_reg[15:1]};
      if (phase_reg == ph_cmd && cmd_done) begin
        o_last_cmd <= cmd_next;
        bit_cnt_reg <= 5'h00;
        case (cmd_next)
          `SPV_CMD_LOAD_CFG, `SPV_CMD_LOAD_DATA: phase_reg <= ph_load;
          `SPV_CMD_READ_DATA: phase_reg <= ph_read;
          default: phase_reg <= ph_cmd;
        endcase
      end else if (phase_reg != ph_cmd && frame_done) begin
        phase_reg <= ph_cmd;
        bit_cnt_reg <= 5'h00;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // load latch: bits 1..14 of the frame only
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !mode_reg) begin
      load_reg <= 14'h0000;
      loaded_reg <= 1'b0;
    end else if (phase_reg == ph_load && frame_done) begin
      load_reg <= sh_reg[15:2];
      loaded_reg <= 1'b1;
    end else if (phase_reg == ph_cmd && cmd_done && cmd_next == `SPV_CMD_END_PROG) begin
      loaded_reg <= 1'b0;
    end
  end

  // word pointer: user space on entry, jumps and increments
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !mode_reg) begin
      ptr_reg <= 14'h0000;
    end else if (phase_reg == ph_cmd && cmd_done) begin
      if (cmd_next == `SPV_CMD_LOAD_CFG) begin
        ptr_reg <= `SPV_CFG_BASE;
      end else if (cmd_next == `SPV_CMD_INC_ADDR) begin
        ptr_reg <= ptr_inc(ptr_reg);
      end
    end
  end
  assign o_word_pointer = ptr_reg;

  // programming pulse runs begin to end; needs a prior load
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !mode_reg) begin
      o_prog_active <= 1'b0;
    end else if (phase_reg == ph_cmd && cmd_done) begin
      if (cmd_next == `SPV_CMD_BEGIN_PROG && loaded_reg) begin
        o_prog_active <= 1'b1;
      end else if (cmd_next == `SPV_CMD_END_PROG) begin
        o_prog_active <= 1'b0;
      end
    end
  end

  // otp cell model: programming clears bits, one pass per pulse start
  always_ff @(posedge i_sys_clk) begin
    if (phase_reg == ph_cmd && cmd_done && cmd_next == `SPV_CMD_BEGIN_PROG && loaded_reg) begin
      if (ptr_reg[13]) begin
        cfg[ptr_reg[7:0]] <= cfg_q & load_reg;
      end else begin
        mem[ptr_reg[11:0]] <= mem_q & load_reg;
      end
    end
  end

  // read driver: out from rising edge of cycle two to rising edge of cycle sixteen
  logic [15:0] tx_reg;
  logic [4:0] rise_cnt_reg;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !mode_reg || phase_reg != ph_read) begin
      link.dev_data_oe <= 1'b0;
      link.dev_data_o <= 1'b0;
      rise_cnt_reg <= 5'h00;
      tx_reg <= {1'b0, rd_word, 1'b0};
    end else if (rise) begin
      rise_cnt_reg <= rise_cnt_reg + 5'h01;
      if (rise_cnt_reg == 5'h01) begin
        link.dev_data_oe <= 1'b1;
        link.dev_data_o <= tx_reg[1];
        tx_reg <= {1'b0, tx_reg[15:1]};
      end else if (rise_cnt_reg == 5'(`SPV_FRAME_BITS - 1)) begin
        link.dev_data_oe <= 1'b0;
        link.dev_data_o <= 1'b0;
      end else if (rise_cnt_reg > 5'h01) begin
        link.dev_data_o <= tx_reg[1];
        tx_reg <= {1'b0, tx_reg[15:1]};
      end
    end
  end
endmodule // spv_device
`default_nettype wire

// [rtl/spv_host.sv]
// programmer end: entry sequence, command and frame shifting
`default_nettype none
`include "spv_regs.svh"
module spv_host #(
  parameter int HOLD_CYC = `SPV_HOLD_CYC,
  parameter int GAP_CYC = `SPV_GAP_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  spv_if.host link,
  input wire logic i_enable,
  input wire logic i_req_valid,
  input wire spv_pkg::cmd_t i_req_cmd,
  input wire spv_pkg::word_t i_req_data,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output spv_pkg::word_t o_rsp_data,
  input wire logic i_rsp_ready
);
  import spv_pkg::*;

  initial begin
    if (HOLD_CYC < 1 || GAP_CYC < 1) $error("counts must be positive");
  end

  // ==========================================================
  // two-entry request buffer
  logic [19:0] buf_q [0:1];
  logic [1:0] cnt_reg;
  logic wr_ptr_reg, rd_ptr_reg, take;
  logic [1:0] cnt_next;
  // ready is registered from the next count so the output leaves a flop
  assign cnt_next = cnt_reg + 2'(i_req_valid && o_req_ready) - 2'(take);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= 2'd0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      o_req_ready <= 1'b1;
    end else begin
      o_req_ready <= (cnt_next != 2'd2);
      if (i_req_valid && o_req_ready) begin
        buf_q[wr_ptr_reg] <= {i_req_cmd, i_req_data};
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (take) rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================
  // sequencer; half-period enable from divider
  typedef enum logic [2:0] {
    s_off = 3'b000, s_hold = 3'b001, s_idle = 3'b010,
    s_cmd = 3'b011, s_gap = 3'b100, s_frame = 3'b101, s_push = 3'b110
  } hstate_t;
  hstate_t st_reg;
  logic [31:0] wait_reg;
  logic [2:0] div_reg;
  logic [4:0] bit_reg;
  logic [15:0] sh_reg;
  logic [15:0] rx_reg;
  logic is_read, has_frame, ph;
  logic dat_s1, dat_s2;
  wire logic tick = (div_reg == 3'(`SPV_HALF_DIV - 1));
  wire cmd_t head_cmd = buf_q[rd_ptr_reg][19:14];
  assign take = (st_reg == s_idle) && (cnt_reg != 2'd0) && (wait_reg == 32'h0);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
    end else begin
      dat_s1 <= link.prog_data_pin;
      dat_s2 <= dat_s1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_reg <= s_off;
      wait_reg <= 32'h0;
      div_reg <= 3'h0;
      bit_reg <= 5'h00;
      sh_reg <= 16'h0000;
      rx_reg <= 16'h0000;
      ph <= 1'b0;
      is_read <= 1'b0;
      has_frame <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 14'h0000;
      link.prog_clock_pin <= 1'b0;
      link.high_voltage_entry_pin <= 1'b0;
      link.host_data_o <= 1'b0;
      link.host_data_oe <= 1'b1;
    end else begin
      div_reg <= tick ? 3'h0 : div_reg + 3'h1;
      if (wait_reg != 32'h0) wait_reg <= wait_reg - 32'h1;
      if (o_rsp_valid && i_rsp_ready) o_rsp_valid <= 1'b0;
      case (st_reg)
        s_off: if (i_enable) begin
          link.high_voltage_entry_pin <= 1'b1;
          wait_reg <= 32'(HOLD_CYC);
          st_reg <= s_hold;
        end
        s_hold: if (wait_reg == 32'h0) st_reg <= s_idle;
        s_idle: if (!i_enable) begin
          link.high_voltage_entry_pin <= 1'b0;
          st_reg <= s_off;
        end else if (take) begin
          sh_reg <= {10'h000, head_cmd};
          is_read <= (head_cmd == `SPV_CMD_READ_DATA);
          has_frame <= (head_cmd == `SPV_CMD_READ_DATA) ||
            (head_cmd == `SPV_CMD_LOAD_DATA) || (head_cmd == `SPV_CMD_LOAD_CFG);
          rx_reg <= {1'b0, buf_q[rd_ptr_reg][13:0], 1'b0};
          bit_reg <= 5'h00;
          ph <= 1'b0;
          st_reg <= s_cmd;
        end
        s_cmd, s_frame: if (tick && !o_rsp_valid) begin
          ph <= ~ph;
          if (!ph) begin
            link.prog_clock_pin <= 1'b1;
            link.host_data_oe <= !(st_reg == s_frame && is_read);
            link.host_data_o <= sh_reg[0];
          end else begin
            link.prog_clock_pin <= 1'b0;
            if (st_reg == s_frame && is_read) rx_reg <= {dat_s2, rx_reg[15:1]};
            sh_reg <= {1'b0, sh_reg[15:1]};
            bit_reg <= bit_reg + 5'h01;
            if (st_reg == s_cmd && bit_reg == 5'(`SPV_CMD_BITS - 1)) begin
              wait_reg <= 32'(GAP_CYC);
              st_reg <= has_frame ? s_gap : s_idle;
              link.host_data_oe <= 1'b1;
              link.host_data_o <= 1'b0;
            end else if (st_reg == s_frame && bit_reg == 5'(`SPV_FRAME_BITS - 1)) begin
              wait_reg <= 32'(GAP_CYC);
              st_reg <= is_read ? s_push : s_idle;
            end
          end
        end
        s_gap: if (wait_reg == 32'h0) begin
          sh_reg <= rx_reg;
          bit_reg <= 5'h00;
          st_reg <= s_frame;
        end
        s_push: begin
          o_rsp_valid <= 1'b1;
          o_rsp_data <= rx_reg[15:2];
          link.host_data_oe <= 1'b1;
          st_reg <= s_idle;
        end
        default: st_reg <= s_off;
      endcase
    end
  end
endmodule // spv_host
`default_nettype wire

// [testbench/spv_properties.sv]
// link checker for the serial program/verify port
`default_nettype none
`include "spv_regs.svh"
module spv_properties #(
  parameter int HOLD_CYC = 50,
  parameter int GAP_CYC = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic prog_clock_pin,
  input wire logic high_voltage_entry_pin,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic prog_data_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic clk_d;
  int low_run, hold_run, falls, rise_oe;
  // ==========================================
  // run lengths: bit gaps are short, unit gaps long
  always_ff @(posedge i_sys_clk) begin
    clk_d <= prog_clock_pin;
    if (!i_rst_n || prog_clock_pin) begin
      low_run <= 0;
    end else if (low_run < GAP_CYC) begin
      low_run <= low_run + 1;
    end
    if (!high_voltage_entry_pin) begin
      hold_run <= 0;
    end else if (hold_run < HOLD_CYC) begin
      hold_run <= hold_run + 1;
    end
  end
  // falls per unit, and rises while the device drives data
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !high_voltage_entry_pin) begin
      falls <= 0;
    end else if (clk_d && !prog_clock_pin) begin
      falls <= falls + 1;
    end else if (prog_clock_pin && !clk_d && low_run >= GAP_CYC - 1) begin
      falls <= 0;
    end
    if (!i_rst_n || !dev_data_oe) begin
      rise_oe <= 0;
    end else if (prog_clock_pin && !clk_d) begin
      rise_oe <= rise_oe + 1;
    end
  end
  // ==========================================
  // assertions
  AST_ENTRY_QUIET: assert property ($rose(high_voltage_entry_pin) |-> !prog_clock_pin && !prog_data_pin)
    else $error("link clock or data high at mode entry");
  AST_IDLE_OUTSIDE: assert property (!high_voltage_entry_pin |-> !prog_clock_pin && !dev_data_oe)
    else $error("link active outside the mode");
  AST_HOLD: assert property ($rose(prog_clock_pin) |-> hold_run >= HOLD_CYC - 1)
    else $error("clock started before the entry hold");
  AST_GAP: assert property ($rose(prog_clock_pin) |-> low_run <= `SPV_HALF_DIV || low_run >= GAP_CYC - 1)
    else $error("gap between units too short");
  AST_UNIT_LEN: assert property ($rose(prog_clock_pin) && low_run >= GAP_CYC - 1 |-> falls == 0 || falls == `SPV_CMD_BITS || falls == `SPV_FRAME_BITS)
    else $error("unit of wrong clock count");
  AST_SETUP: assert property ($fell(prog_clock_pin) |-> $stable(prog_data_pin))
    else $error("data moved at the capture edge");
  AST_NO_CLASH: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data pin");
  AST_OE_RISE: assert property ($rose(dev_data_oe) |-> prog_clock_pin && high_voltage_entry_pin)
    else $error("device drive not started in a high phase");
  AST_OE_SPAN: assert property ($fell(dev_data_oe) |-> rise_oe == `SPV_FRAME_BITS - 2)
    else $error("device drive span wrong");
  // main scenarios seen
  cover property ($rose(high_voltage_entry_pin));
  cover property ($fell(high_voltage_entry_pin));
  cover property ($fell(dev_data_oe));
endmodule // spv_properties
`default_nettype wire

// [testbench/serial_program_verify_port_tb_top.sv]
// self-checking bench joining programmer end and device end
`default_nettype none
`include "spv_regs.svh"
module serial_program_verify_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import spv_pkg::*;
  localparam int HOLD = 50;
  localparam int GAP = 20;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_enable = 1'b0, i_req_valid = 1'b0, i_rsp_ready = 1'b1;
  cmd_t i_req_cmd = '0;
  word_t i_req_data = '0;
  logic o_req_ready, o_rsp_valid, o_core_reset, o_prog_active;
  word_t o_rsp_data, o_word_pointer, ldw;
  cmd_t o_last_cmd;
  int failures = 0, num_checks = 0, ptr = 0, acc, got, k;
  bit [31:0] seed = 32'h2e30_5a38, r;
  bit loaded, act;
  logic [13:0] zm [int];
  // ==========================================
  // clock, link and both ends
  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  spv_if i_spv_if ();
  spv_host #(.HOLD_CYC(HOLD), .GAP_CYC(GAP)) i_spv_host (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .link(i_spv_if), .i_enable(i_enable), .i_req_valid(i_req_valid),
    .i_req_cmd(i_req_cmd), .i_req_data(i_req_data), .o_req_ready(o_req_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .i_rsp_ready(i_rsp_ready));
  spv_device i_spv_device (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .link(i_spv_if),
    .o_core_reset(o_core_reset), .o_prog_active(o_prog_active),
    .o_word_pointer(o_word_pointer), .o_last_cmd(o_last_cmd));
  spv_properties #(.HOLD_CYC(HOLD), .GAP_CYC(GAP)) i_spv_properties (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .prog_clock_pin(i_spv_if.prog_clock_pin),
    .high_voltage_entry_pin(i_spv_if.high_voltage_entry_pin),
    .host_data_oe(i_spv_if.host_data_oe), .dev_data_oe(i_spv_if.dev_data_oe),
    .prog_data_pin(i_spv_if.prog_data_pin));
  // ==========================================
  // helpers: random source, compare, verdict
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // memory index: config aliases on 256 words, user on 4096
  function automatic int key();
    return ptr[13] ? 'h2000 + ptr % 256 : ptr % 4096;
  endfunction
  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // unprogrammed cells may read unknown, so only bits burnt to zero are compared
  task automatic rdchk();
    check("read word", o_rsp_data & (zm.exists(key()) ? zm[key()] : 14'h0), 14'h0);
  endtask
  // ==========================================
  // entry or exit through the enable level
  task automatic enter(input logic on);
    i_enable <= on;
    for (k = 0; k < 100 && i_spv_if.high_voltage_entry_pin !== on; k++) tick(1);
    tick(4);
    check("core reset", {13'h0, o_core_reset}, {13'h0, on});
    ptr = 0;
    loaded = 0;
    act = 0;
    if (on) check("pointer at entry", o_word_pointer, 14'h0);
  endtask
  // one command, with its frame where it has one, then model update
  task automatic op(input cmd_t c, input word_t d);
    int falls, n;
    logic last, rd;
    falls = 0;
    rd = (c == `SPV_CMD_READ_DATA);
    n = (c == `SPV_CMD_LOAD_CFG || c == `SPV_CMD_LOAD_DATA || rd) ? 22 : 6;
    i_req_cmd <= c;
    i_req_data <= d;
    i_req_valid <= 1'b1;
    do @(posedge i_sys_clk); while (!o_req_ready);
    i_req_valid <= 1'b0;
    last = i_spv_if.prog_clock_pin;
    for (int j = 0; j < 4000 && (falls < n || rd); j++) begin
      @(posedge i_sys_clk);
      if (o_rsp_valid && i_rsp_ready) begin
        rd = 1'b0;
        rdchk();
      end
      if (last && !i_spv_if.prog_clock_pin) falls++;
      last = i_spv_if.prog_clock_pin;
    end
    tick(8);
    check("clock falls", falls[13:0], n[13:0]);
    check("read answer", {13'h0, rd}, 14'h0);
    if (c == `SPV_CMD_LOAD_CFG) ptr = 'h2000;
    if (c == `SPV_CMD_INC_ADDR) ptr = ptr[13] ? 'h2000 + (ptr + 1) % 'h2000 : (ptr + 1) % 'h2000;
    if (c == `SPV_CMD_BEGIN_PROG && loaded) begin
      zm[key()] = (zm.exists(key()) ? zm[key()] : 14'h0) | ~ldw;
      act = 1;
    end
    // end of a pulse uses up the load; the next begin needs a fresh one
    if (c == `SPV_CMD_END_PROG) begin
      act = 0;
      loaded = 0;
    end
    if (n == 22 && !rd) begin
      loaded = (c != `SPV_CMD_READ_DATA) || loaded;
      ldw = (c != `SPV_CMD_READ_DATA) ? d : ldw;
    end
    check("pointer", o_word_pointer & (ptr[13] ? 14'h20FF : 14'h3FFF), ptr & 14'h20FF | ptr & (ptr[13] ? 0 : 'h1F00));
    check("last command", {8'h0, o_last_cmd}, {8'h0, c});
    check("program pulse", {13'h0, o_prog_active}, {13'h0, act});
  endtask
  task automatic prog(input cmd_t ld);
    op(ld, rnd());
    op(`SPV_CMD_BEGIN_PROG, 14'h0);
    op(`SPV_CMD_END_PROG, 14'h0);
    op(`SPV_CMD_READ_DATA, 14'h0);
  endtask
  // ==========================================
  // main sequence
  initial begin
    tick(3);
    i_rst_n <= 1'b1;
    enter(1'b1);
    op(`SPV_CMD_BEGIN_PROG, 14'h0);
    op(`SPV_CMD_END_PROG, 14'h0);
    $display("test entry and refused pulse done");
    prog(`SPV_CMD_LOAD_DATA);
    op(`SPV_CMD_BEGIN_PROG, 14'h0);
    op(`SPV_CMD_END_PROG, 14'h0);
    op(`SPV_CMD_INC_ADDR, 14'h0);
    prog(`SPV_CMD_LOAD_DATA);
    $display("test user words done");
    prog(`SPV_CMD_LOAD_CFG);
    op(`SPV_CMD_INC_ADDR, 14'h0);
    prog(`SPV_CMD_LOAD_DATA);
    repeat (256) op(`SPV_CMD_INC_ADDR, 14'h0);
    op(`SPV_CMD_READ_DATA, 14'h0);
    $display("test configuration space done");
    enter(1'b0);
    enter(1'b1);
    op(`SPV_CMD_READ_DATA, 14'h0);
    $display("test re-entry done");
    // stalled answers: requests pile up until the buffer refuses
    i_rsp_ready <= 1'b0;
    acc = 0;
    i_req_cmd <= `SPV_CMD_READ_DATA;
    i_req_valid <= 1'b1;
    for (k = 0; k < 1500 && acc < 6; k++) begin
      @(posedge i_sys_clk);
      if (o_req_ready) acc++;
    end
    i_req_valid <= 1'b0;
    check("ready when full", {13'h0, o_req_ready}, 14'h0);
    got = 0;
    for (k = 0; k < 20000 && got < acc; k++) begin
      @(posedge i_sys_clk);
      if (o_rsp_valid && i_rsp_ready) begin
        got++;
        rdchk();
      end
      r = rnd();
      i_rsp_ready <= r[0];
    end
    check("answers", got[13:0], acc[13:0]);
    $display("test buffer stall done");
    end_sim();
  end
  // hang guard
  initial begin
    tick(100000);
    failures++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim();
  end
endmodule // serial_program_verify_port_tb_top
`default_nettype wire
